/* design/drm_register_map.sv */
// dual-bank register map reached over the serial digital interface
//
// How it works
// - Registers are bytes in a 32-location address space.
// - The command byte carries the start address and the transfer begins there.
// - The address counter steps after each register and stops after one register more than the count in the command byte.
// - Stepping applies to reads and writes alike, and writes to read-only bits change nothing.
// - Stepping past the last implemented register wraps the counter to address zero.
// - Every register of both banks can be read or written whichever bank is active.
// - A clear-on-access bit reads its current value and is then cleared by the read or write.
// - A mirrored bank-B bit reads the bank-A value and, if clear-on-access, is cleared by access.
// - The soft reset bit exists only in the first configuration byte of bank A, read and write.
// - The PLL lock status bit shows the inverse of the live PLL state in both banks and ignores writes.
// - The low-voltage flag latches the detector and clears on any access through either bank.
// - The output enable is written only through bank A and bank B reads the bank-A value.
// - The signal-strength bits read the converter output directly in both banks.
// - The active-bank indicator reads one for bank A and zero for bank B in both banks.
// - The bank select bit of each on/off duration register chooses the controlling bank.
`timescale 1ns/1ps
`default_nettype none
module drm_register_map (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               reset,
    // serial link pins
    input  wire logic               select_n,
    input  wire logic               serial_clk,
    input  wire logic               serial_data_in,
    input  wire logic               miso_in,
    output logic                    miso_out,
    output logic                    miso_oe_n,
    // receiver status
    input  wire logic               pll_locked,
    input  wire logic               low_voltage_det,
    input  wire logic [7:0]         rssi_value,
    // receiver control
    output drm_pkg::drm_bank_s      active_bank,
    output logic                    bank_a_active,
    output logic                    shared_output_enable,
    output logic                    soft_reset,
    output logic                    gain_reset_request
);

    typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_DATA, ST_DONE} drm_state_e;

    // synchronised pins
    drm_pkg::drm_pins_s pins_raw, pins;
    logic [drm_pkg::SYNC_BITS-1:0] pins_clean;

    assign pins_raw = '{low_voltage_det: low_voltage_det, pll_locked: pll_locked,
                        serial_data_in: serial_data_in, serial_clk: serial_clk, select_n: select_n};
    assign pins     = drm_pkg::drm_pins_s'(pins_clean);

    drm_pin_sync u_sync (
        .clk        (clk),
        .reset      (reset),
        .pins_in    (pins_raw),
        .pins_clean (pins_clean)
    );

    // read-back of the shared wire, watched so that a fight on it shows up
    logic miso_seen;
    assign miso_seen = miso_in;

    // link edges
    logic sclk_prev_reg, sclk_prev_next;
    logic rise, fall, frame;
    assign rise  = pins.serial_clk & ~sclk_prev_reg;
    assign fall  = ~pins.serial_clk & sclk_prev_reg;
    assign frame = ~pins.select_n;

    // byte shifter
    logic       byte_valid;
    logic [7:0] byte_data;
    logic       load;
    logic [7:0] load_data;
    logic       shift_dout;

    // transfer state
    drm_state_e state_reg, state_next;
    logic [4:0] addr_reg, addr_next;
    logic [1:0] count_reg, count_next;
    logic       write_reg, write_next;
    logic       oe_n_reg, oe_n_next;

    // register storage and shared bits
    logic [7:0] mem_reg [drm_pkg::NUM_REGS];
    logic [7:0] mem_next [drm_pkg::NUM_REGS];
    logic       low_v_reg, low_v_next;
    logic       bank_a_reg, bank_a_next;
    drm_pkg::drm_bank_s act_reg, act_next;
    logic       soe_reg, soft_reg, gain_reg;

    // access decode
    logic       wr_en;
    logic [4:0] acc_addr;
    logic       access;
    logic [4:0] addr_step;

    drm_byte_shift u_shift (
        .clk        (clk),
        .reset      (reset),
        .clear      (~frame),
        .rise       (rise),
        .fall       (fall),
        .din        (pins.serial_data_in),
        .load       (load),
        .load_data  (load_data),
        .byte_valid (byte_valid),
        .byte_data  (byte_data),
        .dout       (shift_dout)
    );

    function automatic logic [7:0] reset_value(input logic [4:0] a);
        case (a)
            drm_pkg::A_CFG1_ADDR, drm_pkg::B_CFG1_ADDR: reset_value = drm_pkg::CFG1_RST;
            drm_pkg::A_CFG2_ADDR, drm_pkg::B_CFG2_ADDR: reset_value = drm_pkg::CFG2_RST;
            drm_pkg::A_CFG3_ADDR, drm_pkg::B_CFG3_ADDR: reset_value = drm_pkg::CFG3_RST;
            drm_pkg::A_CMD_ADDR, drm_pkg::B_CMD_ADDR:   reset_value = drm_pkg::CMD_RST;
            default:                                    reset_value = 8'h00;
        endcase
    endfunction : reset_value

    // read-only bits are simply absent from the mask
    function automatic logic [7:0] write_mask(input logic [4:0] a);
        case (a)
            drm_pkg::B_CFG1_ADDR:                       write_mask = drm_pkg::CFG1_B_WMASK;
            drm_pkg::B_CFG2_ADDR:                       write_mask = drm_pkg::CFG2_B_WMASK;
            drm_pkg::A_CFG3_ADDR, drm_pkg::B_CFG3_ADDR: write_mask = drm_pkg::CFG3_WMASK;
            drm_pkg::A_CMD_ADDR, drm_pkg::B_CMD_ADDR:   write_mask = drm_pkg::CMD_WMASK;
            drm_pkg::A_RSSI_ADDR, drm_pkg::B_RSSI_ADDR: write_mask = 8'h00;
            default:                                    write_mask = (a > drm_pkg::LAST_ADDR) ? 8'h00 : 8'hff;
        endcase
    endfunction : write_mask

    // read view of any address, shared bits overlaid on storage
    function automatic logic [7:0] read_byte(input logic [4:0] a);
        logic [7:0] v;
        v = (a > drm_pkg::LAST_ADDR) ? 8'h00 : mem_reg[a];
        case (a)
            drm_pkg::A_CFG3_ADDR, drm_pkg::B_CFG3_ADDR: begin
                v[drm_pkg::PLL_LOCK_BIT] = ~pins.pll_locked;
                v[drm_pkg::LOW_V_BIT]    = low_v_reg;
            end
            drm_pkg::B_CFG2_ADDR: begin
                v[drm_pkg::OUT_EN_BIT] = mem_reg[drm_pkg::A_CFG2_ADDR][drm_pkg::OUT_EN_BIT];
            end
            drm_pkg::A_CMD_ADDR, drm_pkg::B_CMD_ADDR: begin
                v[drm_pkg::BANK_IND_BIT] = bank_a_reg;
            end
            drm_pkg::A_RSSI_ADDR, drm_pkg::B_RSSI_ADDR: begin
                v = rssi_value;
            end
            default: begin
            end
        endcase
        read_byte = v;
    endfunction : read_byte

    // next address with wrap past the last implemented register
    assign addr_step = (addr_reg >= drm_pkg::LAST_ADDR) ? 5'h00 : addr_reg + 5'h01;

    // transfer sequencing
    always_comb begin
        state_next     = state_reg;
        addr_next      = addr_reg;
        count_next     = count_reg;
        write_next     = write_reg;
        oe_n_next      = oe_n_reg;
        sclk_prev_next = pins.serial_clk;
        load           = 1'b0;
        load_data      = 8'h00;
        wr_en          = 1'b0;
        acc_addr       = addr_reg;
        if (!frame) begin
            state_next = ST_IDLE;
            oe_n_next  = 1'b1;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    state_next = ST_CMD;
                end
                ST_CMD: begin
                    if (byte_valid) begin
                        addr_next  = byte_data[4:0];
                        count_next = byte_data[drm_pkg::CMD_COUNT_LSB +: 2];
                        write_next = byte_data[drm_pkg::CMD_WRITE_BIT];
                        state_next = ST_DATA;
                        if (!byte_data[drm_pkg::CMD_WRITE_BIT]) begin
                            acc_addr  = byte_data[4:0];
                            load      = 1'b1;
                            load_data = read_byte(byte_data[4:0]);
                            oe_n_next = 1'b0;
                        end
                    end
                end
                ST_DATA: begin
                    if (byte_valid) begin
                        wr_en = write_reg;
                        if (count_reg == 2'h0) begin
                            state_next = ST_DONE;
                            oe_n_next  = 1'b1;
                        end else begin
                            count_next = count_reg - 2'h1;
                            addr_next  = addr_step;
                            if (!write_reg) begin
                                acc_addr  = addr_step;
                                load      = 1'b1;
                                load_data = read_byte(addr_step);
                            end
                        end
                    end
                end
                ST_DONE: begin
                    oe_n_next = 1'b1;
                end
            endcase
        end
    end

    assign access = load | wr_en;

    // storage, latched flag and bank choice
    always_comb begin
        for (int i = 0; i < drm_pkg::NUM_REGS; i++) begin
            mem_next[i] = mem_reg[i];
        end
        // any address of either bank, regardless of the active bank
        if (wr_en && acc_addr <= drm_pkg::LAST_ADDR) begin
            mem_next[acc_addr] = (mem_reg[acc_addr] & ~write_mask(acc_addr))
                               | (byte_data & write_mask(acc_addr));
        end
        // detector set beats an access clear in the same cycle
        if (pins.low_voltage_det) begin
            low_v_next = 1'b1;
        end else if (access && (acc_addr == drm_pkg::A_CFG3_ADDR || acc_addr == drm_pkg::B_CFG3_ADDR)) begin
            low_v_next = 1'b0;
        end else begin
            low_v_next = low_v_reg;
        end
        // each bank hands control over with its own select bit
        if (bank_a_reg) begin
            bank_a_next = ~mem_reg[drm_pkg::A_ONOFF_ADDR][drm_pkg::BANK_SEL_BIT];
        end else begin
            bank_a_next = mem_reg[drm_pkg::B_ONOFF_ADDR][drm_pkg::BANK_SEL_BIT];
        end
        if (bank_a_reg) begin
            act_next = {mem_reg[drm_pkg::A_CFG1_ADDR], mem_reg[drm_pkg::A_CFG2_ADDR],
                        mem_reg[drm_pkg::A_CFG3_ADDR], mem_reg[drm_pkg::A_CMD_ADDR]};
        end else begin
            act_next = {mem_reg[drm_pkg::B_CFG1_ADDR], mem_reg[drm_pkg::B_CFG2_ADDR],
                        mem_reg[drm_pkg::B_CFG3_ADDR], mem_reg[drm_pkg::B_CMD_ADDR]};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg     <= ST_IDLE;
            addr_reg      <= 5'h00;
            count_reg     <= 2'h0;
            write_reg     <= 1'b0;
            oe_n_reg      <= 1'b1;
            sclk_prev_reg <= 1'b0;
            low_v_reg     <= 1'b0;
            bank_a_reg    <= 1'b1;
            act_reg       <= {drm_pkg::CFG1_RST, drm_pkg::CFG2_RST, drm_pkg::CFG3_RST, drm_pkg::CMD_RST};
            soe_reg       <= 1'b0;
            soft_reg      <= 1'b0;
            gain_reg      <= 1'b0;
            for (int i = 0; i < drm_pkg::NUM_REGS; i++) begin
                mem_reg[i] <= reset_value(5'(i));
            end
        end else begin
            state_reg     <= state_next;
            addr_reg      <= addr_next;
            count_reg     <= count_next;
            write_reg     <= write_next;
            oe_n_reg      <= oe_n_next;
            sclk_prev_reg <= sclk_prev_next;
            low_v_reg     <= low_v_next;
            bank_a_reg    <= bank_a_next;
            act_reg       <= act_next;
            soe_reg       <= mem_next[drm_pkg::A_CFG2_ADDR][drm_pkg::OUT_EN_BIT];
            soft_reg      <= mem_next[drm_pkg::A_CFG1_ADDR][drm_pkg::SOFT_RESET_BIT];
            gain_reg      <= mem_next[drm_pkg::A_CMD_ADDR][drm_pkg::GAIN_RESET_BIT];
            for (int i = 0; i < drm_pkg::NUM_REGS; i++) begin
                mem_reg[i] <= mem_next[i];
            end
        end
    end

    assign miso_out             = shift_dout;
    assign miso_oe_n            = oe_n_reg;
    assign active_bank          = act_reg;
    assign bank_a_active        = bank_a_reg;
    assign shared_output_enable = soe_reg;
    assign soft_reset           = soft_reg;
    assign gain_reset_request   = gain_reg;

    // checks
    a_lowv_set_wins: assert property (@(posedge clk) disable iff (reset)
        pins.low_voltage_det |=> low_v_reg)
        else $error("low-voltage flag lost a detector event");

    a_lowv_access_clear: assert property (@(posedge clk) disable iff (reset)
        (access && !pins.low_voltage_det && acc_addr == drm_pkg::B_CFG3_ADDR) |=> !low_v_reg)
        else $error("low-voltage flag not cleared by bank-B access");

    a_addr_wraps: assert property (@(posedge clk) disable iff (reset)
        (state_reg == ST_DATA && byte_valid && count_reg != 2'h0 && frame
         && addr_reg == drm_pkg::LAST_ADDR) |=> addr_reg == 5'h00)
        else $error("address counter did not wrap to zero");

    a_count_stops: assert property (@(posedge clk) disable iff (reset)
        (state_reg == ST_DATA && byte_valid && count_reg == 2'h0 && frame)
        |=> state_reg == ST_DONE ##1 (state_reg == ST_DONE || !frame))
        else $error("transfer ran past its register count");

    a_start_addr: assert property (@(posedge clk) disable iff (reset)
        (state_reg == ST_CMD && byte_valid && frame) |=> addr_reg == $past(byte_data[4:0]))
        else $error("transfer did not start at the command address");

    a_ro_rssi_kept: assert property (@(posedge clk) disable iff (reset)
        (wr_en && acc_addr == drm_pkg::B_RSSI_ADDR) |=> $stable(mem_reg[drm_pkg::B_RSSI_ADDR]))
        else $error("write changed a read-only register");

    a_rssi_direct: assert property (@(posedge clk) disable iff (reset)
        (load && (acc_addr == drm_pkg::A_RSSI_ADDR || acc_addr == drm_pkg::B_RSSI_ADDR))
        |-> load_data == rssi_value)
        else $error("signal strength read not taken from converter");

    a_bank_b_soe: assert property (@(posedge clk) disable iff (reset)
        (wr_en && acc_addr == drm_pkg::B_CFG2_ADDR) |=> ##1 soe_reg == $past(soe_reg, 2))
        else $error("bank-B write moved the output enable");

    a_bank_indicator: assert property (@(posedge clk) disable iff (reset)
        (load && acc_addr == drm_pkg::B_CMD_ADDR) |-> load_data[drm_pkg::BANK_IND_BIT] == bank_a_reg)
        else $error("bank indicator differs from active bank");

    a_gain_no_self_clear: assert property (@(posedge clk) disable iff (reset)
        (gain_reg && !(wr_en && acc_addr == drm_pkg::A_CMD_ADDR)) |=> gain_reg)
        else $error("gain reset request cleared itself");

    a_miso_readback: assert property (@(posedge clk) disable iff (reset)
        !oe_n_reg |-> miso_seen == shift_dout)
        else $error("shared data wire differs from the driven bit");

endmodule : drm_register_map
`default_nettype wire

/* design/drm_pkg.sv */
// shared constants and types of the dual-bank register map
package drm_pkg;

    // address space and map limits
    localparam int        ADDR_SPACE     = 32;
    localparam int        ADDR_W         = 5;
    localparam logic [4:0] LAST_ADDR     = 5'h19;
    localparam int        NUM_REGS       = 26;

    // bank A offsets
    localparam logic [4:0] A_CFG1_ADDR   = 5'h00;
    localparam logic [4:0] A_CFG2_ADDR   = 5'h01;
    localparam logic [4:0] A_CFG3_ADDR   = 5'h02;
    localparam logic [4:0] A_CMD_ADDR    = 5'h03;
    localparam logic [4:0] A_ONOFF_ADDR  = 5'h09;
    localparam logic [4:0] A_RSSI_ADDR   = 5'h0c;
    // bank B offsets
    localparam logic [4:0] B_CFG1_ADDR   = 5'h0d;
    localparam logic [4:0] B_CFG2_ADDR   = 5'h0e;
    localparam logic [4:0] B_CFG3_ADDR   = 5'h0f;
    localparam logic [4:0] B_CMD_ADDR    = 5'h10;
    localparam logic [4:0] B_ONOFF_ADDR  = 5'h16;
    localparam logic [4:0] B_RSSI_ADDR   = 5'h19;

    // reset values
    localparam logic [7:0] CFG1_RST      = 8'h91;
    localparam logic [7:0] CFG2_RST      = 8'h10;
    localparam logic [7:0] CFG3_RST      = 8'h30;
    localparam logic [7:0] CMD_RST       = 8'h09;

    // write masks of the mixed-access registers
    localparam logic [7:0] CFG1_B_WMASK  = 8'hf7;
    localparam logic [7:0] CFG2_B_WMASK  = 8'hfe;
    localparam logic [7:0] CFG3_WMASK    = 8'hcf;
    localparam logic [7:0] CMD_WMASK     = 8'hde;

    // bit positions
    localparam int        SOFT_RESET_BIT = 3;
    localparam int        OUT_EN_BIT     = 0;
    localparam int        PLL_LOCK_BIT   = 5;
    localparam int        LOW_V_BIT      = 4;
    localparam int        GAIN_RESET_BIT = 2;
    localparam int        BANK_IND_BIT   = 0;
    localparam int        BANK_SEL_BIT   = 7;

    // command byte fields
    localparam int        CMD_WRITE_BIT  = 7;
    localparam int        CMD_COUNT_LSB  = 5;

    // synchroniser
    localparam int        SYNC_BITS      = 5;
    localparam logic [4:0] SYNC_RST      = 5'h01;

    // pins sampled from outside the clock domain
    typedef struct packed {
        logic low_voltage_det;
        logic pll_locked;
        logic serial_data_in;
        logic serial_clk;
        logic select_n;
    } drm_pins_s;

    // one configuration bank
    typedef struct packed {
        logic [7:0] first_configuration_byte;
        logic [7:0] second_configuration_byte;
        logic [7:0] third_configuration_byte;
        logic [7:0] command_byte;
    } drm_bank_s;

endpackage : drm_pkg

/* design/drm_pin_sync.sv */
// three-stage synchroniser for the pins of the serial link and status lines
`timescale 1ns/1ps
`default_nettype none
module drm_pin_sync (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          reset,
    // raw pins and filtered levels
    input  wire logic [drm_pkg::SYNC_BITS-1:0] pins_in,
    output logic      [drm_pkg::SYNC_BITS-1:0] pins_clean
);

    genvar i;
    generate
        for (i = 0; i < drm_pkg::SYNC_BITS; i++) begin : g_bit
            logic s1_reg, s2_reg, s3_reg, clean_reg;
            logic clean_next;

            // the first stage feeds only the second
            always_comb begin
                clean_next = (s2_reg == s3_reg) ? s2_reg : clean_reg;
            end

            always_ff @(posedge clk) begin
                if (reset) begin
                    s1_reg    <= drm_pkg::SYNC_RST[i];
                    s2_reg    <= drm_pkg::SYNC_RST[i];
                    s3_reg    <= drm_pkg::SYNC_RST[i];
                    clean_reg <= drm_pkg::SYNC_RST[i];
                end else begin
                    s1_reg    <= pins_in[i];
                    s2_reg    <= s1_reg;
                    s3_reg    <= s2_reg;
                    clean_reg <= clean_next;
                end
            end

            assign pins_clean[i] = clean_reg;
        end
    endgenerate

endmodule : drm_pin_sync
`default_nettype wire

/* design/drm_byte_shift.sv */
// byte shifter of the serial link: samples and shifts out on the synchronised rise
`timescale 1ns/1ps
`default_nettype none
module drm_byte_shift (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // link events
    input  wire logic       clear,
    input  wire logic       rise,
    input  wire logic       fall,
    input  wire logic       din,
    // parallel side
    input  wire logic       load,
    input  wire logic [7:0] load_data,
    output logic            byte_valid,
    output logic      [7:0] byte_data,
    output logic            dout
);

    logic [2:0] cnt_reg, cnt_next;
    logic [7:0] in_reg, in_next;
    logic [7:0] out_reg, out_next;
    logic [7:0] data_reg, data_next;
    logic       valid_reg, valid_next;
    logic       armed_reg, armed_next;

    always_comb begin
        cnt_next   = cnt_reg;
        in_next    = in_reg;
        out_next   = out_reg;
        data_next  = data_reg;
        valid_next = 1'b0;
        armed_next = armed_reg;
        if (clear) begin
            cnt_next = 3'h0;
        end else if (rise) begin
            in_next  = {in_reg[6:0], din};
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'h7) begin
                valid_next = 1'b1;
                data_next  = {in_reg[6:0], din};
            end
        end
        // the next bit moves out on the rise that took the current one: the synchronised
        // fall comes too late for a half period of four clocks
        // a freshly loaded byte moves only after the host has closed the bit cell with a fall
        if (load) begin
            out_next   = load_data;
            armed_next = 1'b0;
        end else if (rise && armed_reg) begin
            out_next = {out_reg[6:0], 1'b0};
        end else if (fall) begin
            armed_next = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_reg   <= 3'h0;
            in_reg    <= 8'h00;
            out_reg   <= 8'h00;
            data_reg  <= 8'h00;
            valid_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else begin
            cnt_reg   <= cnt_next;
            in_reg    <= in_next;
            out_reg   <= out_next;
            data_reg  <= data_next;
            valid_reg <= valid_next;
            armed_reg <= armed_next;
        end
    end

    assign byte_valid = valid_reg;
    assign byte_data  = data_reg;
    assign dout       = out_reg[7];

endmodule : drm_byte_shift
`default_nettype wire

/* verification/drm_host_model.sv */
// host model driving the serial link
`timescale 1ns/1ps
`default_nettype none
module drm_host_model (
    // clock
    input  wire logic clk,
    // link
    input  wire logic miso_out,
    input  wire logic miso_oe_n,
    output logic      select_n,
    output logic      serial_clk,
    output logic      serial_data_in,
    output logic      miso_line
);
    logic last_bit = 1'b0;
    // a released line shows the inverse of its last value
    assign miso_line = miso_oe_n ? ~last_bit : miso_out;
    always @(posedge clk) if (!miso_oe_n) last_bit <= miso_out;
    initial begin
        select_n = 1'b1;
        serial_clk = 1'b0;
        serial_data_in = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // link clock stands low outside frames
    task automatic frame(input logic on);
        tick(4);
        select_n = ~on;
        tick(4);
    endtask : frame
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            serial_data_in = tx[i];
            tick(4);
            serial_clk = 1'b1;
            rx[i] = miso_line;
            tick(4);
            serial_clk = 1'b0;
        end
    endtask : xbyte
endmodule : drm_host_model
`default_nettype wire

/* verification/drm_register_map_tb_top.sv */
// self-checking bench of the dual-bank register map
`timescale 1ns/1ps
`default_nettype none
module drm_register_map_tb_top;
    logic               clk, reset, pll_locked, low_voltage_det, select_n, serial_clk, serial_data_in;
    logic               miso_line, miso_out, miso_oe_n, bank_a_active, shared_output_enable;
    logic               soft_reset, gain_reset_request;
    logic [7:0]         rssi_value, rx;
    drm_pkg::drm_bank_s active_bank;
    int                 miscompares = 0;
    int                 checked = 0;
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    drm_host_model u_host (.clk(clk), .miso_out(miso_out), .miso_oe_n(miso_oe_n), .select_n(select_n),
        .serial_clk(serial_clk), .serial_data_in(serial_data_in), .miso_line(miso_line));
    drm_register_map u_dut (.clk(clk), .reset(reset), .select_n(select_n), .serial_clk(serial_clk),
        .serial_data_in(serial_data_in), .miso_in(miso_line), .miso_out(miso_out), .miso_oe_n(miso_oe_n),
        .pll_locked(pll_locked), .low_voltage_det(low_voltage_det), .rssi_value(rssi_value),
        .active_bank(active_bank), .bank_a_active(bank_a_active), .soft_reset(soft_reset),
        .shared_output_enable(shared_output_enable), .gain_reset_request(gain_reset_request));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic burst(input logic [7:0] cmd, input logic [7:0] e [4], input int n);
        u_host.frame(1'b1);
        u_host.xbyte(cmd, rx);
        for (int i = 0; i < n; i++) begin
            u_host.xbyte(8'h00, rx);
            chk("read byte", e[i], rx);
        end
        u_host.frame(1'b0);
    endtask : burst
    task automatic wr(input logic [4:0] addr, input logic [7:0] data);
        u_host.frame(1'b1);
        u_host.xbyte({3'b100, addr}, rx);
        u_host.xbyte(data, rx);
        u_host.frame(1'b0);
    endtask : wr
    task automatic print_verdict;
        if (miscompares == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        print_verdict();
    end
    initial begin
        reset = 1'b1;
        pll_locked = 1'b0;
        low_voltage_det = 1'b1;
        rssi_value = 8'h5a;
        repeat (5) @(posedge clk);
        #1 reset = 1'b0;
        u_host.tick(8);
        low_voltage_det = 1'b0;
        burst(8'h60, '{8'h91, 8'h10, 8'h30, 8'h09}, 4);
        burst(8'h39, '{8'h5a, 8'h91, 8'h00, 8'h00}, 2);
        rssi_value = ~rssi_value;
        wr(5'h19, 8'h00);
        burst(8'h0c, '{8'ha5, 8'h00, 8'h00, 8'h00}, 1);
        pll_locked = ~pll_locked;
        low_voltage_det = ~low_voltage_det;
        u_host.tick(8);
        low_voltage_det = ~low_voltage_det;
        burst(8'h0f, '{8'h10, 8'h00, 8'h00, 8'h00}, 1);
        burst(8'h02, '{8'h00, 8'h00, 8'h00, 8'h00}, 1);
        wr(5'h01, 8'h11);
        chk("output enable", 8'h01, {7'h00, shared_output_enable});
        wr(5'h0e, 8'h00);
        chk("output enable", 8'h01, {7'h00, shared_output_enable});
        burst(8'h0e, '{8'h01, 8'h00, 8'h00, 8'h00}, 1);
        wr(5'h00, 8'h99);
        chk("soft reset", 8'h01, {7'h00, soft_reset});
        wr(5'h0d, 8'hff);
        burst(8'h0d, '{8'hf7, 8'h00, 8'h00, 8'h00}, 1);
        wr(5'h03, 8'h04);
        u_host.tick(20);
        chk("gain reset", 8'h01, {7'h00, gain_reset_request});
        wr(5'h03, 8'h00);
        chk("gain reset", 8'h00, {7'h00, gain_reset_request});
        wr(5'h09, 8'h80);
        chk("bank a active", 8'h00, {7'h00, bank_a_active});
        burst(8'h10, '{8'h08, 8'h00, 8'h00, 8'h00}, 1);
        burst(8'h03, '{8'h00, 8'h00, 8'h00, 8'h00}, 1);
        print_verdict();
    end
endmodule : drm_register_map_tb_top
`default_nettype wire
